//--- rtl/kps_pkg.sv
// constants and types for the keypad scan pin, reset and alert block
package kps_pkg;
    localparam int SENSE_W = 8;
    localparam int DRIVE_W = 10;
    localparam int PIN_W   = SENSE_W + DRIVE_W;

    // clock and timing
    localparam int CLK_NS            = 50;
    localparam int DEB_TICK_NS       = 50000;
    localparam int DEB_TICK_CYC      = DEB_TICK_NS / CLK_NS;
    localparam int ALERT_MIN_NS      = 20000;
    localparam int ALERT_MAX_NS      = 60000;
    localparam int ALERT_MIN_CYC     = (ALERT_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int ALERT_MAX_CYC     = ALERT_MAX_NS / CLK_NS;
    localparam int ALERT_DLY_CYC     = ALERT_MIN_CYC;
    localparam int CLR_MAX_NS        = 200;
    localparam int CLR_MAX_CYC       = CLR_MAX_NS / CLK_NS;
    localparam int DETECT_MAX_NS     = 25000;
    localparam int DETECT_MAX_CYC    = DETECT_MAX_NS / CLK_NS;
    localparam int MASK_MAX_S        = 31;
    localparam int RST_HOLD_CYC      = 2;

    localparam logic [1:0] PIN_MODE_GPI  = 2'h0;
    localparam logic [1:0] PIN_MODE_GPO  = 2'h1;
    localparam logic [1:0] PIN_MODE_KEY  = 2'h2;

    localparam logic [PIN_W-1:0]   PIN_RST_HI  = {PIN_W{1'b1}};
    localparam logic [PIN_W-1:0]   PIN_RST_LO  = {PIN_W{1'b0}};
    localparam logic [DRIVE_W-1:0] DRV_ALL_OFF = {DRIVE_W{1'b1}};
    localparam logic [11:0]        DEB_CNT_RST = 12'h000;
    localparam logic [10:0]        DLY_CNT_RST = 11'h000;
    localparam logic [5:0]         MASK_S_RST  = 6'h00;

    typedef enum logic [1:0] {KPS_IDLE, KPS_WAIT, KPS_ASSERT} kps_alert_t;
endpackage

//--- rtl/kps_debounce.sv
// two-stage debounce of one pin, sampled on each debounce tick
`timescale 1ns/1ns
module kps_debounce (
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_tick,
    input  wire logic i_pin,
    output logic      o_level
);
    import kps_pkg::*;
    logic sync1_reg, sync2_reg, st1_reg, st2_reg;
    logic st1_next, st2_next;

    // ----------------------------------------------------------------
    // debounce stages
    // ----------------------------------------------------------------
    // R15: two stages agree
    always_comb begin
        st1_next = st1_reg;
        st2_next = st2_reg;
        if (i_tick) begin
            st1_next = sync2_reg;
            if (sync2_reg == st1_reg) begin
                st2_next = st1_reg;
            end
        end
    end

    // pins idle high through the pull-ups
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            st1_reg   <= 1'b1;
            st2_reg   <= 1'b1;
        end else begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
            st1_reg   <= st1_next;
            st2_reg   <= st2_next;
        end
    end

    assign o_level = st2_reg;
endmodule

//--- rtl/kps_pins_alert.sv
// pin modes, reset merge, debounce and host alert timing
`timescale 1ns/1ns

// Overview of operation
// R1: pins power up inputs with pull-ups
// R2: each pin input, output or matrix
// R3: general mode outputs are push-pull
// R4: keyscan sense lines open-drain pulled-up inputs
// R5: keyscan drive lines pull low only
// R6: reset low clears all state
// R7: reset pin equals power-on reset
// R8: power-on reset holds until released
// R9: open-drain alert on input change
// R10: alert valid 20 to 60 us after event
// R11: host clear releases alerts within 200ns
// R12: key change detected within 25 us; here a pin change is flagged only after two debounce ticks, 50 to 100 us
// R13: interrupt mask timer up to 31 s
// R14: locked keypad keys raise alert if selected
// R15: two-stage debounce on 50 us tick
module kps_pins_alert (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_por_n,
    input  wire logic [kps_pkg::PIN_W*2-1:0] i_pin_mode,
    input  wire logic [kps_pkg::PIN_W-1:0]   i_gpo_value,
    input  wire logic [kps_pkg::PIN_W-1:0]   i_pin_in,
    input  wire logic [kps_pkg::DRIVE_W-1:0] i_drive_strobe_n,
    input  wire logic                   i_key_event,
    input  wire logic                   i_unlock_event,
    input  wire logic                   i_overflow_event,
    input  wire logic                   i_combo_event,
    input  wire logic                   i_lock_on,
    input  wire logic                   i_lock_alert_en,
    input  wire logic                   i_second_tick,
    input  wire logic [5:0]             i_mask_seconds,
    input  wire logic                   i_host_clear,
    output logic [kps_pkg::PIN_W-1:0]   o_pin_out,
    output logic [kps_pkg::PIN_W-1:0]   o_pin_oe_n,
    output logic [kps_pkg::PIN_W-1:0]   o_pullup_en,
    output logic [kps_pkg::PIN_W-1:0]   o_pin_level,
    output logic                        o_alert_n_out,
    output logic                        o_alert_n_oe_n,
    output logic                        o_combo_alert_n_out,
    output logic                        o_combo_alert_n_oe_n,
    output logic                        o_in_reset
);
    import kps_pkg::*;

    // ----------------------------------------------------------------
    // reset merge
    // ----------------------------------------------------------------
    logic rn_s1_reg, rn_s2_reg, por_s1_reg, por_s2_reg, rst_reg;
    logic rst_next;

    // R7: pin and power-on share one reset
    always_comb begin
        rst_next = i_sys_rst | ~rn_s2_reg | ~por_s2_reg;
    end

    // R6: synchronise the reset sources
    // R8: power-on low holds reset
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rn_s1_reg  <= 1'b0;
            rn_s2_reg  <= 1'b0;
            por_s1_reg <= 1'b0;
            por_s2_reg <= 1'b0;
            rst_reg    <= 1'b1;
        end else begin
            rn_s1_reg  <= i_reset_n;
            rn_s2_reg  <= rn_s1_reg;
            por_s1_reg <= i_por_n;
            por_s2_reg <= por_s1_reg;
            rst_reg    <= rst_next;
        end
    end

    // ----------------------------------------------------------------
    // debounce tick and pin debouncers
    // ----------------------------------------------------------------
    logic [11:0]      deb_cnt_reg, deb_cnt_next;
    logic             tick;
    logic [PIN_W-1:0] deb_level;

    always_comb begin
        tick         = (deb_cnt_reg == 12'(DEB_TICK_CYC - 1));
        deb_cnt_next = tick ? DEB_CNT_RST : deb_cnt_reg + 12'h001;
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst_reg) begin
            deb_cnt_reg <= DEB_CNT_RST;
        end else begin
            deb_cnt_reg <= deb_cnt_next;
        end
    end

    // R15: one debouncer per pin
    for (genvar g = 0; g < PIN_W; g++) begin : g_deb
        kps_debounce u_deb (
            .i_sys_clk (i_sys_clk),
            .i_sys_rst (rst_reg),
            .i_tick    (tick),
            .i_pin     (i_pin_in[g]),
            .o_level   (deb_level[g])
        );
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] out_next, oe_n_next, pu_next, gpi_prev_reg;
    logic             gpi_change;
    logic [1:0]       md;

    // R2: per-pin mode select
    always_comb begin
        out_next   = PIN_RST_LO;
        oe_n_next  = PIN_RST_HI;
        pu_next    = PIN_RST_HI;
        gpi_change = 1'b0;
        md         = PIN_MODE_GPI;
        for (int p = 0; p < PIN_W; p++) begin
            md = i_pin_mode[2*p +: 2];
            if (md == PIN_MODE_GPO) begin
                // R3: push-pull drive both levels
                out_next[p]  = i_gpo_value[p];
                oe_n_next[p] = 1'b0;
                pu_next[p]   = 1'b0;
            end else if (md == PIN_MODE_KEY && p >= SENSE_W) begin
                // R5: drive line pulls low only
                oe_n_next[p] = i_drive_strobe_n[p-SENSE_W];
                pu_next[p]   = 1'b0;
            end else if (md == PIN_MODE_GPI) begin
                // R12: debounced change flagged at once
                gpi_change = gpi_change
                           | (deb_level[p] != gpi_prev_reg[p]);
            end
            // R4: sense lines stay pulled-up inputs
        end
    end

    // R1: reset leaves every pin an input with pull-up
    always_ff @(posedge i_sys_clk) begin
        if (rst_reg) begin
            o_pin_out    <= PIN_RST_LO;
            o_pin_oe_n   <= PIN_RST_HI;
            o_pullup_en  <= PIN_RST_HI;
            o_pin_level  <= PIN_RST_HI;
            gpi_prev_reg <= PIN_RST_HI;
        end else begin
            o_pin_out    <= out_next;
            o_pin_oe_n   <= oe_n_next;
            o_pullup_en  <= pu_next;
            o_pin_level  <= deb_level;
            gpi_prev_reg <= deb_level;
        end
    end

    // ----------------------------------------------------------------
    // mask timer and alert sequencing
    // ----------------------------------------------------------------
    kps_alert_t  st_reg, st_next;
    logic [10:0] dly_reg, dly_next;
    logic [5:0]  mask_reg, mask_next;
    logic        pend_reg, pend_next, combo_reg, combo_next;
    logic        cpend_reg, cpend_next;
    logic        ev, lock_ok;

    always_comb begin
        // R14: locked keys alert only when selected
        lock_ok   = ~i_lock_on | (i_lock_alert_en && mask_reg == MASK_S_RST);
        ev        = (i_key_event & lock_ok) | i_unlock_event
                  | i_overflow_event | gpi_change;
        mask_next = mask_reg;
        // R13: mask timer counts down in seconds
        if (i_lock_on && i_key_event && mask_reg == MASK_S_RST) begin
            mask_next = (i_mask_seconds > 6'(MASK_MAX_S))
                      ? 6'(MASK_MAX_S) : i_mask_seconds;
        end else if (i_second_tick && mask_reg != MASK_S_RST) begin
            mask_next = mask_reg - 6'h01;
        end
        // R9: event arms a pending alert
        pend_next  = pend_reg | ev;
        cpend_next = cpend_reg | i_combo_event;
        st_next    = st_reg;
        dly_next   = dly_reg;
        combo_next = combo_reg;
        unique case (st_reg)
            KPS_IDLE: begin
                if (ev | i_combo_event) begin
                    st_next  = KPS_WAIT;
                    dly_next = DLY_CNT_RST;
                end
            end
            // R10: wait the least valid time
            KPS_WAIT: begin
                dly_next = dly_reg + 11'h001;
                if (dly_reg == 11'(ALERT_DLY_CYC - 1)) begin
                    st_next    = KPS_ASSERT;
                    combo_next = cpend_reg;
                end
            end
            KPS_ASSERT: begin
                combo_next = combo_reg | cpend_reg;
            end
        endcase
        // R11: host clear drops both alerts next edge
        if (i_host_clear) begin
            st_next    = (ev | i_combo_event) ? KPS_WAIT : KPS_IDLE;
            dly_next   = DLY_CNT_RST;
            pend_next  = ev;
            cpend_next = i_combo_event;
            combo_next = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst_reg) begin
            st_reg    <= KPS_IDLE;
            dly_reg   <= DLY_CNT_RST;
            mask_reg  <= MASK_S_RST;
            pend_reg  <= 1'b0;
            cpend_reg <= 1'b0;
            combo_reg <= 1'b0;
        end else begin
            st_reg    <= st_next;
            dly_reg   <= dly_next;
            mask_reg  <= mask_next;
            pend_reg  <= pend_next;
            cpend_reg <= cpend_next;
            combo_reg <= combo_next;
        end
    end

    // open-drain alerts only ever pull low
    always_ff @(posedge i_sys_clk) begin
        o_alert_n_out        <= 1'b0;
        o_combo_alert_n_out  <= 1'b0;
        o_in_reset           <= rst_reg;
        o_alert_n_oe_n       <= ~(st_next == KPS_ASSERT) | rst_reg;
        o_combo_alert_n_oe_n <= ~combo_next | rst_reg;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_reset_pins: assert property (@(posedge i_sys_clk) // R1
        rst_reg |=> (o_pin_oe_n == PIN_RST_HI && o_pullup_en == PIN_RST_HI))
        else $error("pins not inputs with pull-ups after reset");
    a_reset_merge: assert property (@(posedge i_sys_clk) // R7
        disable iff (i_sys_rst) !rn_s2_reg |=> rst_reg)
        else $error("reset pin did not reset block");
    a_por_hold: assert property (@(posedge i_sys_clk) // R8
        disable iff (i_sys_rst) !por_s2_reg |=> rst_reg)
        else $error("power-on reset did not hold");
    a_reg_clear: assert property (@(posedge i_sys_clk) // R6
        rst_reg |=> (st_reg == KPS_IDLE && !pend_reg))
        else $error("state not cleared by reset");
    // R10: cycles an alert has waited unshown
    logic [10:0] late_cnt_reg, late_cnt_next;

    always_comb begin
        late_cnt_next = DLY_CNT_RST;
        if (st_reg != KPS_IDLE && o_alert_n_oe_n && !(&late_cnt_reg)) begin
            late_cnt_next = late_cnt_reg + 11'h001;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst_reg) begin
            late_cnt_reg <= DLY_CNT_RST;
        end else begin
            late_cnt_reg <= late_cnt_next;
        end
    end

    a_alert_min: assert property (@(posedge i_sys_clk) // R10
        disable iff (rst_reg)
        $fell(o_alert_n_oe_n) |-> late_cnt_reg >= 11'(ALERT_MIN_CYC))
        else $error("alert rose too early");
    a_alert_late: assert property (@(posedge i_sys_clk) // R10
        disable iff (rst_reg) late_cnt_reg <= 11'(ALERT_MAX_CYC))
        else $error("alert later than allowed");
    a_clear_fast: assert property (@(posedge i_sys_clk) // R11
        disable iff (rst_reg)
        (i_host_clear && !ev && !i_combo_event)
        |=> (o_alert_n_oe_n && o_combo_alert_n_oe_n))
        else $error("alert not released after clear");
    a_drive_low: assert property (@(posedge i_sys_clk) // R5
        disable iff (rst_reg)
        (i_pin_mode[2*SENSE_W +: 2] == PIN_MODE_KEY)
        |=> !o_pin_out[SENSE_W])
        else $error("drive line driven high");
    a_deb_tick: assert property (@(posedge i_sys_clk) // R15
        disable iff (rst_reg) tick |=> !tick [*8])
        else $error("debounce tick too frequent");
endmodule

//--- testbench/kps_host_model.sv
// host model: answers the alert lines with a clear pulse
`timescale 1ns/1ns
module kps_host_model (
    input  wire logic i_sys_clk,
    input  wire logic i_alert_line,
    input  wire logic i_combo_line,
    input  wire logic i_slow,
    output logic      o_host_clear
);
    // --------------------
    // interrupt service
    // --------------------
    // serve a pulled-low alert promptly or after a slow delay
    initial begin
        o_host_clear = 1'b0;
        forever begin
            @(negedge i_sys_clk);
            if (!(i_alert_line && i_combo_line)) begin
                repeat (i_slow ? 30 : 1) @(negedge i_sys_clk);
                o_host_clear = 1'b1;
                @(negedge i_sys_clk);
                o_host_clear = 1'b0;
                @(negedge i_sys_clk);
            end
        end
    end
endmodule

//--- testbench/tb.sv
// self-checking bench for the pin, reset and alert block
`timescale 1ns/1ns
module tb;
    import kps_pkg::*;
    logic               i_sys_clk, i_sys_rst, i_reset_n, i_por_n;
    logic [PIN_W*2-1:0] i_pin_mode;
    logic [PIN_W-1:0]   i_gpo_value, ext_pin, i_pin_in, exp_oe, exp_out;
    logic [DRIVE_W-1:0] i_drive_strobe_n;
    logic               i_key_event, i_unlock_event, i_overflow_event;
    logic               i_combo_event, i_lock_on, i_lock_alert_en;
    logic               i_second_tick, i_host_clear, slow, mute;
    logic [5:0]         mask_s;
    logic [PIN_W-1:0]   o_pin_out, o_pin_oe_n, o_pullup_en, o_pin_level;
    logic               o_alert_n_out, o_alert_n_oe_n, o_in_reset;
    logic               o_combo_alert_n_out, o_combo_alert_n_oe_n;
    logic               alert_line, combo_line;
    logic               prev_alert = 1'b1;
    int                 num_errors = 0, check_count = 0, cyc = 0;
    int                 ev_cyc, clr_cyc, n, p;
    integer             seed;
    logic               exp_q[$];

    // pin and alert wires resolved from each driver's enable
    assign i_pin_in   = (o_pin_oe_n & ext_pin) | (~o_pin_oe_n & o_pin_out);
    assign alert_line = o_alert_n_oe_n ? 1'b1 : o_alert_n_out;
    assign combo_line = o_combo_alert_n_oe_n ? 1'b1 : o_combo_alert_n_out;

    kps_pins_alert uut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_reset_n(i_reset_n), .i_por_n(i_por_n), .i_pin_mode(i_pin_mode),
        .i_gpo_value(i_gpo_value), .i_pin_in(i_pin_in),
        .i_drive_strobe_n(i_drive_strobe_n), .i_key_event(i_key_event),
        .i_unlock_event(i_unlock_event), .i_overflow_event(i_overflow_event),
        .i_combo_event(i_combo_event), .i_lock_on(i_lock_on),
        .i_lock_alert_en(i_lock_alert_en), .i_second_tick(i_second_tick),
        .i_mask_seconds(mask_s), .i_host_clear(i_host_clear),
        .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
        .o_pullup_en(o_pullup_en), .o_pin_level(o_pin_level),
        .o_alert_n_out(o_alert_n_out), .o_alert_n_oe_n(o_alert_n_oe_n),
        .o_combo_alert_n_out(o_combo_alert_n_out),
        .o_combo_alert_n_oe_n(o_combo_alert_n_oe_n), .o_in_reset(o_in_reset));

    kps_host_model host (.i_sys_clk(i_sys_clk), .i_alert_line(alert_line),
        .i_combo_line(combo_line), .i_slow(slow), .o_host_clear(i_host_clear));

    // --------------------
    // clock and helpers
    // --------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    // cycle count and moment of the last host clear
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (i_host_clear) clr_cyc <= cyc;
    end

    // mask timer tick every 2000 cycles (100 us), standing in for one second
    always @(negedge i_sys_clk) i_second_tick <= (cyc % 2000 == 0);

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one-cycle event pulse: 0 key, 1 unlock, 2 overflow, 3 combo
    task automatic fire(input int k);
        @(negedge i_sys_clk);
        {i_combo_event, i_overflow_event, i_unlock_event, i_key_event} =
            4'h1 << k;
        ev_cyc = cyc;
        @(negedge i_sys_clk);
        {i_combo_event, i_overflow_event, i_unlock_event, i_key_event} = 4'h0;
    endtask

    // wait until every noted alert was seen and served
    task automatic wait_idle();
        n = 0;
        while ((exp_q.size() != 0 || !alert_line || !combo_line) && n < 3000)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        check(n < 3000, 1'b1);
    endtask

    task automatic wait_level(input logic [PIN_W-1:0] v);
        n = 0;
        while (o_pin_level !== v && n < 2 * DEB_TICK_CYC + 20) begin
            @(negedge i_sys_clk);
            n++;
        end
        ev_cyc = cyc;
        check(o_pin_level, v);
    endtask

    // alert monitor: each falling alert while mute is low takes the oldest note
    always @(negedge i_sys_clk) begin
        prev_alert <= alert_line;
        if (prev_alert && !alert_line && !mute) begin
            if (exp_q.size() == 0) check(1'b1, 1'b0);
            else check(cyc - ev_cyc inside {[ALERT_MIN_CYC:ALERT_MAX_CYC]},
                       exp_q.pop_front());
        end
        // release counted from the edge that took the clear
        if (!prev_alert && alert_line && o_in_reset === 1'b0)
            check(cyc - clr_cyc <= CLR_MAX_CYC + 1, 1'b1);
    end

    // --------------------
    // watchdog
    // --------------------
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end

    // --------------------
    // test sequence
    // --------------------
    initial begin
        seed = 32'hc536;
        {i_key_event, i_unlock_event, i_overflow_event, i_combo_event} = 4'h0;
        {i_lock_on, i_lock_alert_en, slow, mute} = 4'h0;
        mask_s = 6'h00;
        i_sys_rst = 1'b1;
        i_reset_n = 1'b1;
        i_por_n = 1'b0;
        i_pin_mode = {PIN_W{PIN_MODE_GPI}};
        i_gpo_value = PIN_RST_LO;
        i_drive_strobe_n = DRV_ALL_OFF;
        ext_pin = PIN_RST_HI;
        repeat (4) @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        repeat (6) @(negedge i_sys_clk);
        check(o_in_reset, 1'b1);
        i_por_n = 1'b1;
        repeat (8) @(negedge i_sys_clk);
        check(o_in_reset, 1'b0);
        check(o_pin_oe_n, PIN_RST_HI);
        check(o_pullup_en, PIN_RST_HI);
        $display("test power-up done");
        // each event kind, prompt and slow host
        for (int k = 0; k < 3; k++) begin
            slow = k[0];
            exp_q.push_back(1'b1);
            fire(k);
            wait_idle();
        end
        mute = 1'b1;
        fire(3);
        n = 0;
        while (combo_line && n < ALERT_MAX_CYC + 10) begin
            @(negedge i_sys_clk);
            n++;
        end
        check(cyc - ev_cyc inside {[ALERT_MIN_CYC:ALERT_MAX_CYC]}, 1'b1);
        while (!combo_line && n < 3000) begin
            @(negedge i_sys_clk);
            n++;
        end
        check(cyc - clr_cyc <= CLR_MAX_CYC + 1, 1'b1);
        wait_idle();
        mute = 1'b0;
        $display("test alert timing done");
        // locked keys alert only when selected and unmasked
        mask_s = 6'h02;
        i_lock_on = 1'b1;
        i_lock_alert_en = 1'b1;
        exp_q.push_back(1'b1);
        fire(0);
        wait_idle();
        for (int k = 0; k < 2; k++) begin
            i_lock_alert_en = k[0];
            fire(0);
            repeat (ALERT_MAX_CYC + 20) @(negedge i_sys_clk);
        end
        repeat (1400) @(negedge i_sys_clk);
        exp_q.push_back(1'b1);
        fire(0);
        wait_idle();
        i_lock_on = 1'b0;
        $display("test lock done");
        // short glitch never passes, then press and release
        p = $unsigned($random(seed)) % PIN_W;
        ext_pin[p] = 1'b0;
        repeat (100) @(negedge i_sys_clk);
        ext_pin[p] = 1'b1;
        n = 0;
        repeat (2500) begin
            @(negedge i_sys_clk);
            n += (o_pin_level !== PIN_RST_HI);
        end
        check(n, 0);
        for (int k = 0; k < 2; k++) begin
            exp_q.push_back(1'b1);
            ext_pin[p] = k[0];
            wait_level(k ? PIN_RST_HI : PIN_RST_HI & ~(PIN_W'(1) << p));
            wait_idle();
        end
        $display("test debounce done");
        // matrix sense, matrix drive and output pins
        for (int q = 0; q < PIN_W; q++)
            i_pin_mode[2*q +: 2] = (q < 13) ? PIN_MODE_KEY : PIN_MODE_GPO;
        repeat (2) begin
            i_gpo_value = PIN_W'($random(seed));
            i_drive_strobe_n = DRIVE_W'($random(seed));
            repeat (4) @(negedge i_sys_clk);
            exp_oe = {5'h00, i_drive_strobe_n[4:0], 8'hff};
            exp_out = {i_gpo_value[17:13], 13'h0000};
            check(o_pin_oe_n, exp_oe);
            check(o_pin_out & ~o_pin_oe_n, exp_out & ~exp_oe);
            check(o_pullup_en[7:0], 8'hff);
        end
        i_gpo_value = PIN_RST_HI;
        i_drive_strobe_n = DRV_ALL_OFF;
        repeat (2 * DEB_TICK_CYC + 50) @(negedge i_sys_clk);
        $display("test pin modes done");
        // reset pin aborts a pending alert and restores pins
        fire(0);
        repeat (50) @(negedge i_sys_clk);
        i_reset_n = 1'b0;
        repeat (4) @(negedge i_sys_clk);
        check(o_in_reset, 1'b1);
        check(o_pin_oe_n, PIN_RST_HI);
        check(o_pullup_en, PIN_RST_HI);
        i_pin_mode = {PIN_W{PIN_MODE_GPI}};
        i_reset_n = 1'b1;
        repeat (8) @(negedge i_sys_clk);
        check(o_in_reset, 1'b0);
        repeat (ALERT_MAX_CYC + 20) @(negedge i_sys_clk);
        check(exp_q.size() == 0, 1'b1);
        $display("test reset pin done");
        give_verdict();
    end
endmodule
